/* hdl/rtm_pkg.sv */
// package: register map, field layout, thresholds and states for the rise-time engine
`default_nettype none
package rtm_pkg;
  // register word indices; byte address is index times four
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_LOWER = 4'h1;
  localparam logic [3:0] REG_UPPER = 4'h2;
  localparam logic [3:0] REG_REF_LOW = 4'h3;
  localparam logic [3:0] REG_REF_HIGH = 4'h4;
  localparam logic [3:0] REG_PERIOD = 4'h5;
  localparam logic [3:0] REG_STATUS = 4'h6;
  localparam logic [3:0] REG_RESULT = 4'h7;
  // command codes: long form and short form behave the same
  localparam logic [3:0] CMD_RISE_TIME_LONG = 4'h1;
  localparam logic [3:0] CMD_RISE_INTERVAL_SHORT_FORM = 4'h2;
  // source codes: inputs 0..3, stored waveforms 4..7, math 8..9
  localparam int NUM_SRC = 10;
  localparam logic [3:0] SRC_INPUT1 = 4'h0;
  localparam logic [3:0] SRC_LAST = 4'h9;
  // percent thresholds in hundredths of a percent
  localparam logic signed [31:0] PERCENT_FULL = 32'sd10000;
  localparam logic signed [31:0] PERCENT_MIN = -32'sd2500;
  localparam logic signed [31:0] PERCENT_MAX = 32'sd12500;
  localparam logic signed [31:0] DEF_LOW_PERCENT = 32'sd1000;
  localparam logic signed [31:0] DEF_HIGH_PERCENT = 32'sd9000;
  // volt thresholds in millivolts
  localparam logic signed [31:0] VOLT_MIN = -32'sd250000000;
  localparam logic signed [31:0] VOLT_MAX = 32'sd250000000;
  // single-precision pattern of 9.99999e37 for "no signal"
  localparam logic [31:0] NO_SIGNAL_VALUE = 32'h7e96768d;
  // status bit positions
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_DONE_BIT = 1;
  localparam int ST_PARAM_ERR_BIT = 2;
  localparam int ST_SCALE_ERR_BIT = 3;
  localparam int ST_NO_SIGNAL_BIT = 4;
  localparam logic [31:0] PERIOD_RESET = 32'h0000_03e8;

  typedef struct packed {
    logic [18:0] unused;
    logic high_is_volt;
    logic low_is_volt;
    logic upper_given;
    logic lower_given;
    logic src_given;
    logic [3:0] source;
    logic [3:0] cmd;
  } rtm_ctrl_t;

  typedef struct packed {
    logic valid;
    logic last;
    logic [NUM_SRC-1:0][31:0] sample;
  } rtm_wave_t;

  typedef enum logic [2:0] {
    S_IDLE, S_CHECK, S_ARM, S_LOW, S_HIGH, S_CALC
  } rtm_state_t;
endpackage
`default_nettype wire

/* hdl/rtm_rise_time.sv */
// rise-time measurement engine with an avalon-mm register slave
//
// Summary of operation
// (R1) on command, select source, measure, and place the result for reading
// (R2) only the first rising edge of the record is evaluated
// (R3) lower threshold crossing is found first, then upper crossing
// (R4) result equals upper crossing time minus lower crossing time, in seconds
// (R5) thresholds default to 10% and 90% when omitted and after reset
// (R6) percent thresholds accepted only from -25.00% to +125.0%
// (R7) volt thresholds accepted within plus or minus 250,000 volts
// (R8) host never mixes percent and volt units in one command
// (R9) order is low, high, source; low alone uses default high
// (R10) exactly one of four inputs, four memories or two math sources
// (R11) omitted source means analog input 1
// (R12) questionable horizontal scaling raises an error
// (R13) long and short command forms behave identically
// (R14) absent signal returns 9.99999e37 instead of a measurement
// (R15) percent maps linearly from low reference (0%) to high (100%)
//
// Local design decisions: the register offsets and the Avalon-MM slave port.
`default_nettype none
module rtm_rise_time
  import rtm_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic [3:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire rtm_wave_t i_wave,
  output logic o_busy,
  output logic o_done
);

  // percent to level, shared by both thresholds
  function automatic logic signed [31:0] scale_level(input logic signed [31:0] percent,
    input logic signed [31:0] lo, input logic signed [31:0] hi);
    logic signed [63:0] span;
    span = 64'(hi) - 64'(lo);
    return 32'(64'(lo) + (span * 64'(percent)) / 64'(PERCENT_FULL));
  endfunction

  function automatic logic in_range(input logic signed [31:0] v, input logic is_volt);
    in_range = is_volt ? (v >= VOLT_MIN && v <= VOLT_MAX) : (v >= PERCENT_MIN && v <= PERCENT_MAX);
  endfunction

  rtm_ctrl_t ctrl;
  logic signed [31:0] lower_thr;
  logic signed [31:0] upper_thr;
  logic signed [31:0] ref_low;
  logic signed [31:0] ref_high;
  logic [31:0] period;
  logic [31:0] result;
  logic flag_done;
  logic flag_param_err;
  logic flag_scale_err;
  logic flag_no_signal;
  rtm_state_t state;
  logic signed [31:0] lvl_low;
  logic signed [31:0] lvl_high;
  logic [31:0] idx;
  logic [31:0] t_low;
  logic [31:0] t_up;

  // bus decode
  wire req = i_avs_read | i_avs_write;
  wire wr_take = i_avs_write & ~o_avs_waitrequest;
  wire rtm_ctrl_t wr_ctrl = rtm_ctrl_t'(i_avs_writedata);
  wire cmd_ok = (wr_ctrl.cmd == CMD_RISE_TIME_LONG) ||
    (wr_ctrl.cmd == CMD_RISE_INTERVAL_SHORT_FORM);
  // (R13) both forms start
  wire go = wr_take && (i_avs_address == REG_CTRL) && cmd_ok && (state == S_IDLE);
  wire [31:0] status_word = {27'h0, flag_no_signal, flag_scale_err, flag_param_err,
    flag_done, o_busy};
  wire [31:0] rd_mux =
    (i_avs_address == REG_CTRL) ? 32'(ctrl) :
    (i_avs_address == REG_LOWER) ? lower_thr :
    (i_avs_address == REG_UPPER) ? upper_thr :
    (i_avs_address == REG_REF_LOW) ? ref_low :
    (i_avs_address == REG_REF_HIGH) ? ref_high :
    (i_avs_address == REG_PERIOD) ? period :
    (i_avs_address == REG_STATUS) ? status_word :
    (i_avs_address == REG_RESULT) ? result : 32'h0;

  // effective thresholds and source for the latched command
  // (R5) defaults when omitted
  wire signed [31:0] eff_low = ctrl.lower_given ? lower_thr : DEF_LOW_PERCENT;
  // (R9) low alone keeps default high
  wire signed [31:0] eff_high = ctrl.upper_given ? upper_thr : DEF_HIGH_PERCENT;
  wire low_volt = ctrl.lower_given & ctrl.low_is_volt;
  wire high_volt = ctrl.upper_given & ctrl.high_is_volt;
  // (R11) default source
  wire [3:0] src = ctrl.src_given ? ctrl.source : SRC_INPUT1;
  // (R6) (R7) range check; mixed units refused defensively
  wire bad_range = !in_range(eff_low, low_volt) || !in_range(eff_high, high_volt);
  wire mixed = ctrl.lower_given && ctrl.upper_given && (low_volt != high_volt);
  // (R10) one valid source code
  wire bad_src = src > SRC_LAST;
  wire param_bad = bad_range | mixed | bad_src;
  // (R12) zero sample period means no usable time base
  wire scale_bad = (period == 32'h0);
  // (R15) percent relative to reference levels
  wire signed [31:0] next_lvl_low = low_volt ? eff_low : scale_level(eff_low, ref_low, ref_high);
  wire signed [31:0] next_lvl_high =
    high_volt ? eff_high : scale_level(eff_high, ref_low, ref_high);
  wire signed [31:0] cur = bad_src ? 32'sh0 : i_wave.sample[src];
  wire sampling = (state == S_ARM) || (state == S_LOW) || (state == S_HIGH);
  wire smp = i_wave.valid & sampling;
  wire above_low = cur >= lvl_low;
  wire above_high = cur >= lvl_high;
  // (R4) difference of crossing times scaled to time
  wire [63:0] rise_full = 64'(t_up - t_low) * 64'(period);
  wire [31:0] next_result = rise_full[31:0];
  // edge completes on this sample
  wire hit_high = smp && above_high && ((state == S_HIGH) || (state == S_LOW && above_low));
  wire give_up = smp && i_wave.last && !hit_high;

  // bus handshake: one wait cycle, then answer
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata <= 32'h0;
    end
    else
    begin
      o_avs_waitrequest <= !(req && o_avs_waitrequest);
      if (i_avs_read && o_avs_waitrequest)
        o_avs_readdata <= rd_mux;
    end
  end

  // writable registers; threshold and setup writes ignored while busy
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      ctrl <= '0;
      lower_thr <= DEF_LOW_PERCENT;
      upper_thr <= DEF_HIGH_PERCENT;
      ref_low <= 32'sh0;
      ref_high <= 32'sh0;
      period <= PERIOD_RESET;
    end
    else if (wr_take && state == S_IDLE)
    begin
      case (i_avs_address)
        REG_CTRL: if (cmd_ok) ctrl <= wr_ctrl;
        REG_LOWER: lower_thr <= i_avs_writedata;
        REG_UPPER: upper_thr <= i_avs_writedata;
        REG_REF_LOW: ref_low <= i_avs_writedata;
        REG_REF_HIGH: ref_high <= i_avs_writedata;
        REG_PERIOD: period <= i_avs_writedata;
        default: ;
      endcase
    end
  end

  // (R1) measurement sequence
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      state <= S_IDLE;
      lvl_low <= 32'sh0;
      lvl_high <= 32'sh0;
      idx <= 32'h0;
      t_low <= 32'h0;
      t_up <= 32'h0;
    end
    else
    begin
      if (smp)
        idx <= idx + 32'h1;
      case (state)
        S_IDLE:
          if (go)
          begin
            state <= S_CHECK;
            idx <= 32'h0;
          end
        S_CHECK:
        begin
          lvl_low <= next_lvl_low;
          lvl_high <= next_lvl_high;
          state <= (param_bad || scale_bad) ? S_IDLE : S_ARM;
        end
        // (R2) wait below lower level so only a true first edge counts
        S_ARM:
          if (give_up)
            state <= S_IDLE;
          else if (smp && !above_low)
            state <= S_LOW;
        // (R3) lower crossing first
        S_LOW:
          if (hit_high)
          begin
            t_low <= idx;
            t_up <= idx;
            state <= S_CALC;
          end
          else if (give_up)
            state <= S_IDLE;
          else if (smp && above_low)
          begin
            t_low <= idx;
            state <= S_HIGH;
          end
        // (R3) then upper crossing
        S_HIGH:
          if (hit_high)
          begin
            t_up <= idx;
            state <= S_CALC;
          end
          else if (give_up)
            state <= S_IDLE;
        S_CALC:
          state <= S_IDLE;
        default:
          state <= S_IDLE;
      endcase
    end
  end

  // status, result and outputs; flags only cleared by the next start
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      result <= 32'h0;
      flag_done <= 1'b0;
      flag_param_err <= 1'b0;
      flag_scale_err <= 1'b0;
      flag_no_signal <= 1'b0;
      o_busy <= 1'b0;
      o_done <= 1'b0;
    end
    else
    begin
      o_done <= 1'b0;
      if (go)
      begin
        o_busy <= 1'b1;
        flag_done <= 1'b0;
        flag_param_err <= 1'b0;
        flag_scale_err <= 1'b0;
        flag_no_signal <= 1'b0;
      end
      else if (state == S_CHECK && (param_bad || scale_bad))
      begin
        flag_param_err <= param_bad;
        // (R12) time base error
        flag_scale_err <= scale_bad;
        flag_done <= 1'b1;
        o_busy <= 1'b0;
        o_done <= 1'b1;
      end
      else if (sampling && give_up)
      begin
        // (R14) no edge found
        result <= NO_SIGNAL_VALUE;
        flag_no_signal <= 1'b1;
        flag_done <= 1'b1;
        o_busy <= 1'b0;
        o_done <= 1'b1;
      end
      else if (state == S_CALC)
      begin
        // (R4) rise time into result
        result <= next_result;
        flag_done <= 1'b1;
        o_busy <= 1'b0;
        o_done <= 1'b1;
      end
    end
  end

  // bus answers after exactly one wait cycle
  a_bus_wait_one: assert property (@(posedge i_clk) disable iff (!i_rstn)
    req && o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("waitrequest did not drop after one cycle");
  // (R13) short form command starts a measurement
  a_short_form_go: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_avs_write && !o_avs_waitrequest && i_avs_address == REG_CTRL && state == S_IDLE &&
    i_avs_writedata[3:0] == CMD_RISE_INTERVAL_SHORT_FORM |=> state == S_CHECK && o_busy)
    else $error("short form command did not start");
  // (R5) default low level sits 10 percent of span above low reference
  a_default_low: assert property (@(posedge i_clk) disable iff (!i_rstn)
    state == S_CHECK && !ctrl.lower_given |=>
    lvl_low == scale_level(DEF_LOW_PERCENT, ref_low, ref_high))
    else $error("default low level wrong");
  // (R6) lower percent above maximum gives parameter error
  a_percent_range: assert property (@(posedge i_clk) disable iff (!i_rstn)
    state == S_CHECK && ctrl.lower_given && !ctrl.low_is_volt && lower_thr > PERCENT_MAX
    |=> flag_param_err && state == S_IDLE)
    else $error("out of range percent accepted");
  // (R7) volt threshold used directly
  a_volt_level: assert property (@(posedge i_clk) disable iff (!i_rstn)
    state == S_CHECK && !param_bad && !scale_bad && high_volt |=> lvl_high == $past(upper_thr))
    else $error("volt threshold not applied");
  // (R12) zero period flags scale error
  a_scale_error: assert property (@(posedge i_clk) disable iff (!i_rstn)
    state == S_CHECK && period == 32'h0 |=> flag_scale_err && o_done)
    else $error("scale error not raised");
  // (R14) sentinel on missing edge
  a_no_signal: assert property (@(posedge i_clk) disable iff (!i_rstn)
    sampling && give_up |=> result == NO_SIGNAL_VALUE && flag_no_signal && !o_busy)
    else $error("sentinel not returned");
  // (R3) upper crossing never before lower crossing
  a_cross_order: assert property (@(posedge i_clk) disable iff (!i_rstn)
    state == S_CALC |-> t_up >= t_low)
    else $error("upper crossing before lower");
  // (R4) result is the scaled difference
  a_result_calc: assert property (@(posedge i_clk) disable iff (!i_rstn)
    state == S_CALC |=> result == 32'((t_up - t_low) * period) ##1 !o_done)
    else $error("rise time result wrong");
  // (R11) default source is input 1
  a_default_src: assert property (@(posedge i_clk) disable iff (!i_rstn)
    sampling && !ctrl.src_given |-> cur == i_wave.sample[0])
    else $error("default source not input 1");

  c_measure_done: cover property (@(posedge i_clk) disable iff (!i_rstn) state == S_CALC);
  c_no_signal: cover property (@(posedge i_clk) disable iff (!i_rstn) sampling && give_up);
  c_param_err: cover property (@(posedge i_clk) disable iff (!i_rstn)
    state == S_CHECK && param_bad);
  c_volt_mode: cover property (@(posedge i_clk) disable iff (!i_rstn)
    state == S_CHECK && low_volt && high_volt);

endmodule
`default_nettype wire

/* tb/rtm_host_model.sv */
// host-side avalon-mm master that issues rise-time commands
`default_nettype none
module rtm_host_model
  import rtm_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_waitrequest,
  input wire logic [31:0] i_readdata,
  output logic [3:0] o_address,
  output logic o_read,
  output logic o_write,
  output logic [31:0] o_writedata
);
  timeunit 1ns;
  timeprecision 1ns;

  initial
  begin
    o_address = 4'h0;
    o_read = 1'b0;
    o_write = 1'b0;
    o_writedata = 32'h0;
  end

  // request held until waitrequest is sampled low; no fixed latency assumed
  task automatic xfer(input logic [3:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge i_clk);
    o_address <= a;
    o_writedata <= d;
    o_read <= !w;
    o_write <= w;
    do
      @(posedge i_clk);
    while (i_waitrequest !== 1'b0);
    q = i_readdata;
    o_read <= 1'b0;
    o_write <= 1'b0;
  endtask

  // units matched, low then high then one source
  task automatic command(input logic [31:0] lo, input logic [31:0] hi, input rtm_ctrl_t c);
    logic [31:0] q;
    if (c.lower_given && c.upper_given)
      c.high_is_volt = c.low_is_volt;
    xfer(REG_LOWER, 1'b1, lo, q);
    xfer(REG_UPPER, 1'b1, hi, q);
    xfer(REG_CTRL, 1'b1, c, q);
  endtask
endmodule
`default_nettype wire

/* tb/rtm_rise_time_tb.sv */
// self-checking bench for the rise-time engine
`default_nettype none
module rtm_rise_time_tb
  import rtm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk;
  logic i_rstn;
  logic [3:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  rtm_wave_t i_wave;
  logic o_busy;
  logic o_done;
  int n_fail = 0;
  int checks = 0;
  int cycles = 0;
  logic [31:0] wave [9] = '{32'h0, 32'h1f4, 32'h4b0, 32'hbb8, 32'h1f40, 32'h251c, 32'h0,
                            32'h1f4, 32'h2648};

  rtm_rise_time rtm_rise_time_inst (.i_clk(i_clk), .i_rstn(i_rstn),
    .i_avs_address(avs_address), .i_avs_read(avs_read), .i_avs_write(avs_write),
    .i_avs_writedata(avs_writedata), .o_avs_readdata(avs_readdata),
    .o_avs_waitrequest(avs_waitrequest), .i_wave(i_wave), .o_busy(o_busy), .o_done(o_done));
  rtm_host_model rtm_host_model_inst (.i_clk(i_clk), .i_waitrequest(avs_waitrequest),
    .i_readdata(avs_readdata), .o_address(avs_address), .o_read(avs_read),
    .o_write(avs_write), .o_writedata(avs_writedata));

  initial
  begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // run is a few hundred cycles; anything near this ceiling is a hang
  always @(posedge i_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      n_fail++;
      print_verdict();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
      n_fail++;
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    rtm_host_model_inst.xfer(a, 1'b1, d, q);
  endtask

  task automatic rd_chk(input string what, input logic [3:0] a, input logic [31:0] exp);
    logic [31:0] q;
    rtm_host_model_inst.xfer(a, 1'b0, 32'h0, q);
    chk(what, exp, q);
  endtask

  function automatic rtm_ctrl_t mk(input logic [3:0] cmd, input logic [3:0] src,
                                   input logic [4:0] f);
    rtm_ctrl_t c;
    c = '0;
    c.cmd = cmd;
    c.source = src;
    {c.high_is_volt, c.low_is_volt, c.upper_given, c.lower_given, c.src_given} = f;
    return c;
  endfunction

  // unselected sources sit high so a wrong source never arms
  task automatic play(input int src, input int n);
    for (int i = 0; i < n; i++)
    begin
      @(posedge i_clk);
      i_wave.valid <= 1'b1;
      i_wave.last <= (i == n - 1);
      for (int k = 0; k < NUM_SRC; k++)
        i_wave.sample[k] <= (k == src) ? wave[i] : 32'h4e20;
    end
    @(posedge i_clk);
    i_wave.valid <= 1'b0;
    i_wave.last <= 1'b0;
    i_wave.sample <= ~i_wave.sample;
  endtask

  task automatic meas(input logic [31:0] lo, input logic [31:0] hi, input rtm_ctrl_t c,
                      input int src, input int n, input logic [31:0] res, input logic [2:0] err);
    int k;
    rtm_host_model_inst.command(lo, hi, c);
    fork
      begin
        repeat (3) @(posedge i_clk);
        play(src, n);
      end
      begin
        @(posedge i_clk);
        chk("busy after start", 32'h1, {31'h0, o_busy});
        for (k = 0; k < 200 && o_done !== 1'b1; k++)
          @(posedge i_clk);
        chk("done pulse seen", 32'h1, {31'h0, o_done});
        chk("busy at done", 32'h0, {31'h0, o_busy});
      end
    join
    rd_chk("status errors", REG_STATUS, {27'h0, err, 1'b1, 1'b0});
    if (err[1:0] == 2'h0)
      rd_chk("result", REG_RESULT, res);
  endtask

  task automatic cfg(input logic [31:0] lo_ref, input logic [31:0] hi_ref, input logic [31:0] per);
    wr(REG_REF_LOW, lo_ref);
    wr(REG_REF_HIGH, hi_ref);
    wr(REG_PERIOD, per);
  endtask

  task automatic t_regs();
    rd_chk("lower reset", REG_LOWER, 32'h3e8);
    rd_chk("upper reset", REG_UPPER, 32'h2328);
    rd_chk("period reset", REG_PERIOD, PERIOD_RESET);
    rd_chk("status reset", REG_STATUS, 32'h0);
    wr(4'h8, 32'hffffffff);
    rd_chk("unmapped", 4'h8, 32'h0);
    wr(REG_RESULT, 32'h1234);
    rd_chk("result read only", REG_RESULT, 32'h0);
  endtask

  task automatic t_default();
    cfg(32'h0, 32'h2710, 32'h3e8);
    meas(32'h1388, 32'h1388, mk(CMD_RISE_TIME_LONG, 4'h7, 5'h00), 0, 9, 32'hbb8,
      3'h0);
  endtask

  task automatic t_forms();
    cfg(32'h0, 32'h2710, 32'h7);
    meas(32'h7d0, 32'h1b58, mk(CMD_RISE_INTERVAL_SHORT_FORM, 4'h5, 5'h07), 5, 9, 32'h7,
      3'h0);
    wr(REG_PERIOD, 32'hb);
    meas(32'h4b0, 32'h1f40, mk(CMD_RISE_TIME_LONG, 4'h9, 5'h1f), 9, 9, 32'h16, 3'h0);
    wr(REG_PERIOD, 32'h5);
    meas(32'hbb8, 32'h0, mk(CMD_RISE_TIME_LONG, 4'h3, 5'h03), 3, 9, 32'ha, 3'h0);
  endtask

  task automatic t_bounds();
    cfg(32'hfa0, 32'h1f40, 32'h3);
    meas(-32'sh9c4, 32'h30d4, mk(CMD_RISE_TIME_LONG, 4'h8, 5'h07), 8, 9, 32'h6, 3'h0);
  endtask

  task automatic t_errs();
    cfg(32'h0, 32'h2710, 32'h3e8);
    meas(32'h30d5, 32'h2328, mk(CMD_RISE_TIME_LONG, 4'h0, 5'h07), 0, 0, 32'h0, 3'h1);
    meas(-32'sh9c5, 32'h2328, mk(CMD_RISE_TIME_LONG, 4'h0, 5'h07), 0, 0, 32'h0, 3'h1);
    meas(32'h0ee6b281, 32'h0, mk(CMD_RISE_TIME_LONG, 4'h0, 5'h0b), 0, 0, 32'h0, 3'h1);
    meas(32'h0, 32'h0, mk(CMD_RISE_TIME_LONG, 4'ha, 5'h01), 0, 0, 32'h0, 3'h1);
    wr(REG_PERIOD, 32'h0);
    meas(32'h0, 32'h0, mk(CMD_RISE_TIME_LONG, 4'h0, 5'h00), 0, 9, 32'h0, 3'h2);
    wr(REG_PERIOD, 32'h3e8);
    meas(32'h0, 32'h0, mk(CMD_RISE_TIME_LONG, 4'h0, 5'h00), 0, 3, NO_SIGNAL_VALUE, 3'h4);
  endtask

  initial
  begin
    i_rstn = 1'b0;
    i_wave = '0;
    repeat (20) @(posedge i_clk);
    i_rstn <= 1'b1;
    t_regs();
    t_default();
    t_forms();
    t_bounds();
    t_errs();
    print_verdict();
  end
endmodule
`default_nettype wire
